/* File: design/tccp_defs.svh */
/*
 * Constants of the timer channel capture/compare/PWM block: register
 * offsets, control bit positions, reset values and field codes.
 * Assumes it is included by bare name from the package and the modules.
 */
`ifndef TCCP_DEFS_SVH
`define TCCP_DEFS_SVH

// channel count and address decode
`define TCCP_NUM_CH        6
`define TCCP_CH_LAST       3'h5
`define TCCP_ADDR_TOP_ZERO 3'h0
`define TCCP_SUB_CTRL      2'h0
`define TCCP_SUB_VAL_HIGH  2'h1
`define TCCP_SUB_VAL_LOW   2'h2

// channel control/status bit positions
`define TCCP_BIT_FLAG      7
`define TCCP_BIT_IRQ_EN    6
`define TCCP_BIT_BUF_MODE  5
`define TCCP_BIT_MODE_A    4
`define TCCP_BIT_ELS_HI    3
`define TCCP_BIT_ELS_LO    2
`define TCCP_BIT_OVF_TGL   1
`define TCCP_BIT_FULL_DUTY 0

// channels that own a buffered-mode bit (0, 2 and 4)
`define TCCP_BUF_CAPABLE   6'h15

// edge/level select codes
`define TCCP_ELS_OFF       2'h0
`define TCCP_ELS_TOGGLE    2'h1
`define TCCP_ELS_CLEAR     2'h2
`define TCCP_ELS_SET       2'h3

// reset values
`define TCCP_RST_BITS      6'h00
`define TCCP_RST_VALUE     16'h0000
`define TCCP_RST_BYTE      8'h00

`endif

/* File: design/tccp_pkg.sv */
/*
 * Types shared by the channel controller and its per-channel logic.
 * Assumes tccp_defs.svh is on the include path.
 */
`include "tccp_defs.svh"

package tccp_pkg;

    typedef enum logic [1:0] {
        TCCP_MODE_PRESET   = 2'h0,
        TCCP_MODE_CAPTURE  = 2'h1,
        TCCP_MODE_COMPARE  = 2'h2,
        TCCP_MODE_BUFFERED = 2'h3
    } tccp_mode_type;

    typedef struct packed {
        logic [`TCCP_NUM_CH-1:0]       flag;
        logic [`TCCP_NUM_CH-1:0]       irq_en;
        logic [`TCCP_NUM_CH-1:0]       buf_mode;
        logic [`TCCP_NUM_CH-1:0]       mode_a;
        logic [`TCCP_NUM_CH-1:0]       els_hi;
        logic [`TCCP_NUM_CH-1:0]       els_lo;
        logic [`TCCP_NUM_CH-1:0]       ovf_tgl;
        logic [`TCCP_NUM_CH-1:0]       full_duty;
        logic [`TCCP_NUM_CH-1:0]       armed;
        logic [`TCCP_NUM_CH-1:0]       cmp_hold;
        logic [`TCCP_NUM_CH-1:0]       cap_hold;
        logic [`TCCP_NUM_CH-1:0]       phase;
        logic [`TCCP_NUM_CH-1:0][15:0] value;
        logic [7:0]                    rdata;
    } tccp_state_type;

    typedef struct packed {
        logic pin_prev;
        logic out_level;
        logic full_act;
    } tccp_chan_state_type;

endpackage : tccp_pkg

/* File: design/tccp_chan.sv */
/*
 * One timer channel: edge detection for capture, compare match, pin
 * action on match and on counter wrap, and forced full duty.
 * Assumes the controller hands it the effective mode, the compare value
 * already chosen for buffered mode, and the inhibit conditions.
 */
`include "tccp_defs.svh"

module tccp_chan
    import tccp_pkg::*;
(
    input  wire logic          clk_sys,
    input  wire logic          sys_rst,
    input  wire tccp_mode_type mode,
    input  wire logic [1:0]    els,
    input  wire logic          mode_a,
    input  wire logic          ovf_tgl,
    input  wire logic          full_duty,
    input  wire logic [15:0]   counter_value,
    input  wire logic [15:0]   compare_value,
    input  wire logic          counter_wrap,
    input  wire logic          cap_inhibit,
    input  wire logic          cmp_inhibit,
    input  wire logic          pin_in,
    output logic               event_pulse,
    output logic               pin_out,
    output logic               pin_oe
);

    tccp_chan_state_type s_q;
    tccp_chan_state_type s_d;
    logic                rise;
    logic                fall;
    logic                match;
    logic                is_cmp;

    assign rise   = pin_in & ~s_q.pin_prev;
    assign fall   = ~pin_in & s_q.pin_prev;
    assign is_cmp = (mode == TCCP_MODE_COMPARE)
                  | (mode == TCCP_MODE_BUFFERED);
    assign match  = is_cmp & ~cmp_inhibit
                  & (counter_value == compare_value);

    always_comb
    begin
        s_d          = s_q;
        s_d.pin_prev = pin_in;
        event_pulse  = 1'b0;
        unique case (mode)
            TCCP_MODE_PRESET:
            begin
                // preset level waits under port control
                s_d.out_level = ~mode_a;
            end
            TCCP_MODE_CAPTURE:
            begin
                if (!cap_inhibit)
                begin
                    unique case (els)
                        `TCCP_ELS_TOGGLE: event_pulse = rise;
                        `TCCP_ELS_CLEAR:  event_pulse = fall;
                        `TCCP_ELS_SET:    event_pulse = rise | fall;
                        `TCCP_ELS_OFF:    event_pulse = 1'b0;
                    endcase
                end
                // edge raises the event; overflow toggle ignored
            end
            TCCP_MODE_COMPARE, TCCP_MODE_BUFFERED:
            begin
                event_pulse = match;
                if (counter_wrap)
                begin
                    // full duty only changes on a period boundary
                    s_d.full_act = full_duty;
                end
                if (counter_wrap && ovf_tgl)
                begin
                    // wrap beats a same-cycle match
                    s_d.out_level = ~s_q.out_level;
                end
                else if (match)
                begin
                    unique case (els)
                        `TCCP_ELS_TOGGLE: s_d.out_level = ~s_q.out_level;
                        `TCCP_ELS_CLEAR:  s_d.out_level = 1'b0;
                        `TCCP_ELS_SET:    s_d.out_level = 1'b1;
                        `TCCP_ELS_OFF:    s_d.out_level = s_q.out_level;
                    endcase
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // clear-on-compare with overflow toggle is polarity 1: full is high
    assign pin_out = (s_q.full_act && ovf_tgl
                      && els == `TCCP_ELS_CLEAR)
                   ? 1'b1 : s_q.out_level;
    assign pin_oe  = is_cmp & (els != `TCCP_ELS_OFF);

endmodule // tccp_chan

/* File: design/tccp_top.sv */
/*
 * Control and status logic for six capture/compare/PWM channels of a
 * 16-bit timer: channel control registers, channel value registers,
 * event flags with two-step clear, buffered pairing and pin ownership.
 * Assumes an external counter supplies its value, a one-cycle wrap
 * pulse at the modulo value and the halt level; all inputs synchronous.
 */
//
// Behaviour
// - capture channel sets its flag on the selected pin edge
// - compare channel sets its flag when counter equals compare value
// - flag clears by reading status with flag set, then writing zero
// - an event between read and zero write keeps the flag set
// - writing one to the flag does nothing; reset clears it
// - interrupt request only when enable and flag are both one
// - buffered-mode bit exists only on channels 0, 2 and 4
// - buffered even channel disables odd partner register and its pin
// - with edge select nonzero, mode bit A picks capture or compare
// - with edge select zero, mode bit A presets level: one low
// - capture edge: 01 rising, 10 falling, 11 either
// - compare action: 00 none, 01 toggle, 10 clear, 11 set
// - buffered mode ignores mode bit A, same pin actions
// - edge select zero releases the pin to general I/O
// - reset clears mode, edge select and overflow toggle bits
// - overflow toggles compare pin; no effect in capture mode
// - overflow toggle wins over a simultaneous compare
// - full-duty bit forces 100% with overflow toggle and clear action
// - full-duty change takes effect from the next period
// - 100% is high for polarity one, low for zero; the code forces only the high level, with clear action, and never forces low
// - overflow is the counter reaching modulo, then restart at zero
// - high byte write holds compares, high byte read holds captures
// - captures are held off while the counter is halted
//
`include "tccp_defs.svh"

module tccp_top
    import tccp_pkg::*;
(
    input  wire logic                    clk_sys,
    input  wire logic                    sys_rst,
    input  wire logic [7:0]              reg_addr,
    input  wire logic [7:0]              reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [7:0]              reg_rdata,
    input  wire logic [15:0]             counter_value,
    input  wire logic                    counter_wrap,
    input  wire logic                    counter_halt,
    input  wire logic [`TCCP_NUM_CH-1:0] channel_pin_in,
    output logic      [`TCCP_NUM_CH-1:0] channel_pin_out,
    output logic      [`TCCP_NUM_CH-1:0] channel_pin_oe,
    output logic      [`TCCP_NUM_CH-1:0] chan_irq
);

    tccp_state_type                  s_q;
    tccp_state_type                  s_d;
    tccp_mode_type                   mode     [`TCCP_NUM_CH];
    logic [`TCCP_NUM_CH-1:0]         disabled;
    logic [`TCCP_NUM_CH-1:0]         buf_cap;
    logic [`TCCP_NUM_CH-1:0]         ev;
    logic [`TCCP_NUM_CH-1:0]         is_cap;
    logic [`TCCP_NUM_CH-1:0][15:0]   cmp_val;
    logic [2:0]                      ch;
    logic [1:0]                      sub;
    logic                            hit;

    // a macro literal cannot be bit-selected, so give it a net
    assign buf_cap = `TCCP_BUF_CAPABLE;
    assign ch  = reg_addr[4:2];
    assign sub = reg_addr[1:0];
    assign hit = (reg_addr[7:5] == `TCCP_ADDR_TOP_ZERO)
               && (ch <= `TCCP_CH_LAST);

    genvar gi;
    generate
        for (gi = 0; gi < `TCCP_NUM_CH; gi++)
        begin : g_ch
            logic [1:0] els;
            assign els = {s_q.els_hi[gi], s_q.els_lo[gi]};

            if (gi % 2 == 1)
            begin : g_odd
                // partner's buffered bit takes this channel away
                assign disabled[gi] = s_q.buf_mode[gi-1];
            end
            else
            begin : g_even
                assign disabled[gi] = 1'b0;
            end

            always_comb
            begin
                if (disabled[gi] || els == `TCCP_ELS_OFF)
                begin
                    mode[gi] = TCCP_MODE_PRESET;
                end
                else if (s_q.buf_mode[gi])
                begin
                    mode[gi] = TCCP_MODE_BUFFERED;
                end
                else if (s_q.mode_a[gi])
                begin
                    mode[gi] = TCCP_MODE_COMPARE;
                end
                else
                begin
                    mode[gi] = TCCP_MODE_CAPTURE;
                end
            end

            assign is_cap[gi] = (mode[gi] == TCCP_MODE_CAPTURE);

            if (gi % 2 == 0)
            begin : g_sel
                // alternate active register so updates land glitch-free
                assign cmp_val[gi] = (s_q.buf_mode[gi] && s_q.phase[gi])
                                   ? s_q.value[gi+1]
                                   : s_q.value[gi];
            end
            else
            begin : g_nosel
                assign cmp_val[gi] = s_q.value[gi];
            end

            tccp_chan u_chan (
                .clk_sys       (clk_sys),
                .sys_rst       (sys_rst),
                .mode          (mode[gi]),
                .els           (els),
                .mode_a        (s_q.mode_a[gi]),
                .ovf_tgl       (s_q.ovf_tgl[gi]),
                .full_duty     (s_q.full_duty[gi]),
                .counter_value (counter_value),
                .compare_value (cmp_val[gi]),
                .counter_wrap  (counter_wrap),
                .cap_inhibit   (s_q.cap_hold[gi] | counter_halt),
                .cmp_inhibit   (s_q.cmp_hold[gi]),
                .pin_in        (channel_pin_in[gi]),
                .event_pulse   (ev[gi]),
                .pin_out       (channel_pin_out[gi]),
                .pin_oe        (channel_pin_oe[gi])
            );
        end
    endgenerate

    always_comb
    begin
        s_d       = s_q;
        s_d.rdata = `TCCP_RST_BYTE;

        // buffered pairs swap active register at each wrap
        if (counter_wrap)
        begin
            s_d.phase = s_q.phase ^ (s_q.buf_mode
                                     & `TCCP_BUF_CAPABLE);
        end

        // a capture loads the counter into the channel value
        for (int i = 0; i < `TCCP_NUM_CH; i++)
        begin
            if (ev[i] && is_cap[i])
            begin
                s_d.value[i] = counter_value;
            end
        end

        if (reg_rd && hit)
        begin
            unique case (sub)
                `TCCP_SUB_CTRL:
                begin
                    if (!disabled[ch])
                    begin
                        s_d.rdata[`TCCP_BIT_FLAG]      = s_q.flag[ch];
                        s_d.rdata[`TCCP_BIT_IRQ_EN]    = s_q.irq_en[ch];
                        s_d.rdata[`TCCP_BIT_BUF_MODE]  = s_q.buf_mode[ch];
                        s_d.rdata[`TCCP_BIT_MODE_A]    = s_q.mode_a[ch];
                        s_d.rdata[`TCCP_BIT_ELS_HI]    = s_q.els_hi[ch];
                        s_d.rdata[`TCCP_BIT_ELS_LO]    = s_q.els_lo[ch];
                        s_d.rdata[`TCCP_BIT_OVF_TGL]   = s_q.ovf_tgl[ch];
                        s_d.rdata[`TCCP_BIT_FULL_DUTY] = s_q.full_duty[ch];
                        if (s_q.flag[ch])
                        begin
                            s_d.armed[ch] = 1'b1;
                        end
                    end
                end
                `TCCP_SUB_VAL_HIGH:
                begin
                    s_d.rdata = s_q.value[ch][15:8];
                    if (is_cap[ch])
                    begin
                        s_d.cap_hold[ch] = 1'b1;
                    end
                end
                `TCCP_SUB_VAL_LOW:
                begin
                    s_d.rdata        = s_q.value[ch][7:0];
                    s_d.cap_hold[ch] = 1'b0;
                end
                default:
                begin
                    s_d.rdata = `TCCP_RST_BYTE;
                end
            endcase
        end

        if (reg_wr && hit)
        begin
            unique case (sub)
                `TCCP_SUB_CTRL:
                begin
                    // a disabled odd register swallows writes
                    if (!disabled[ch])
                    begin
                        s_d.irq_en[ch]    = reg_wdata[`TCCP_BIT_IRQ_EN];
                        s_d.mode_a[ch]    = reg_wdata[`TCCP_BIT_MODE_A];
                        s_d.els_hi[ch]    = reg_wdata[`TCCP_BIT_ELS_HI];
                        s_d.els_lo[ch]    = reg_wdata[`TCCP_BIT_ELS_LO];
                        s_d.ovf_tgl[ch]   = reg_wdata[`TCCP_BIT_OVF_TGL];
                        s_d.full_duty[ch] = reg_wdata[`TCCP_BIT_FULL_DUTY];
                        s_d.buf_mode[ch]  = reg_wdata[`TCCP_BIT_BUF_MODE]
                                          & buf_cap[ch];
                        // only a zero after an armed read clears
                        if (!reg_wdata[`TCCP_BIT_FLAG] && s_q.armed[ch])
                        begin
                            s_d.flag[ch]  = 1'b0;
                            s_d.armed[ch] = 1'b0;
                        end
                    end
                end
                `TCCP_SUB_VAL_HIGH:
                begin
                    s_d.value[ch][15:8] = reg_wdata;
                    if (!is_cap[ch])
                    begin
                        s_d.cmp_hold[ch] = 1'b1;
                    end
                end
                `TCCP_SUB_VAL_LOW:
                begin
                    s_d.value[ch][7:0] = reg_wdata;
                    s_d.cmp_hold[ch]   = 1'b0;
                end
                default:
                begin
                    s_d.cmp_hold = s_q.cmp_hold;
                end
            endcase
        end

        // events come last so a same-cycle set beats the clear
        for (int i = 0; i < `TCCP_NUM_CH; i++)
        begin
            if (ev[i])
            begin
                s_d.flag[i]  = 1'b1;
                s_d.armed[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            s_q           <= '0;
            s_q.flag      <= `TCCP_RST_BITS;
            s_q.irq_en    <= `TCCP_RST_BITS;
            s_q.buf_mode  <= `TCCP_RST_BITS;
            s_q.mode_a    <= `TCCP_RST_BITS;
            s_q.els_hi    <= `TCCP_RST_BITS;
            s_q.els_lo    <= `TCCP_RST_BITS;
            s_q.ovf_tgl   <= `TCCP_RST_BITS;
            s_q.rdata     <= `TCCP_RST_BYTE;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign reg_rdata = s_q.rdata;
    // odd partner of a buffered pair never requests
    assign chan_irq  = s_q.irq_en & s_q.flag & ~disabled;

endmodule // tccp_top

/* File: sim/tccp_top_props.sv */
/* port-level checks of tccp_top, mostly channel 0 and its partner.
   assumes it is bound to tccp_top; shadows channel 0 setup from writes. */
module tccp_chk
(
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic [7:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    input wire logic [15:0] counter_value,
    input wire logic        counter_wrap,
    input wire logic        counter_halt,
    input wire logic [5:0]  channel_pin_in,
    input wire logic [5:0]  channel_pin_out,
    input wire logic [5:0]  channel_pin_oe,
    input wire logic [5:0]  chan_irq
);
    logic [7:0]  ctl_q;
    logic [15:0] val_q;
    logic        hold_q;
    logic        cmp_md;
    logic        wr0;
    logic        qt;

    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    assign wr0    = reg_wr && reg_addr == 8'h00;
    assign cmp_md = !ctl_q[5] && ctl_q[4] && ctl_q[3:2] != 2'h0;
    // any high-byte access counts as a hold: only narrows what is checked
    assign qt     = !reg_wr && !hold_q;

    always_ff @(posedge clk_sys)
    begin
        if (sys_rst)
        begin
            ctl_q  <= 8'h00;
            val_q  <= 16'h0000;
            hold_q <= 1'b0;
        end
        else
        begin
            if (wr0)
                ctl_q <= reg_wdata;
            if (reg_wr && reg_addr == 8'h01)
                val_q[15:8] <= reg_wdata;
            if (reg_wr && reg_addr == 8'h02)
                val_q[7:0] <= reg_wdata;
            if ((reg_wr || reg_rd) && reg_addr == 8'h01)
                hold_q <= 1'b1;
            else if ((reg_wr || reg_rd) && reg_addr == 8'h02)
                hold_q <= 1'b0;
        end
    end

    property p_rst_idle;
        $past(sys_rst) |-> chan_irq == 6'h00 && channel_pin_oe == 6'h00
            && reg_rdata == 8'h00;
    endproperty
    property p_irq_off;
        wr0 && !reg_wdata[6] |=> !chan_irq[0];
    endproperty
    property p_pin_free;
        wr0 && reg_wdata[3:2] == 2'h0 |=> !channel_pin_oe[0];
    endproperty
    property p_mode_a;
        wr0 && !reg_wdata[5] && reg_wdata[3:2] != 2'h0
            |=> channel_pin_oe[0] == $past(reg_wdata[4]);
    endproperty
    property p_partner_off;
        wr0 && reg_wdata[5] |=> !channel_pin_oe[1] && !chan_irq[1];
    endproperty
    property p_wrap_tgl;
        cmp_md && ctl_q[1] && !ctl_q[0] && counter_wrap && !reg_wr
            |=> channel_pin_out[0] != $past(channel_pin_out[0]);
    endproperty
    property p_cmp_pin;
        cmp_md && !ctl_q[1] && ctl_q[3] && counter_value == val_q
            && !counter_wrap && qt |=> channel_pin_out[0] == ctl_q[2];
    endproperty
    property p_cmp_flag;
        cmp_md && ctl_q[6] && counter_value == val_q && qt |=> chan_irq[0];
    endproperty
    property p_cap_flag;
        !ctl_q[5] && !ctl_q[4] && ctl_q[6] && !counter_halt && qt
            && (ctl_q[2] && $rose(channel_pin_in[0])
            || ctl_q[3] && $fell(channel_pin_in[0])) |=> chan_irq[0];
    endproperty

    a_rst_idle: assert property (p_rst_idle)
        else $error("outputs busy after reset");
    a_irq_off: assert property (p_irq_off)
        else $error("irq with enable clear");
    a_pin_free: assert property (p_pin_free)
        else $error("pin kept with edge select zero");
    a_mode_a: assert property (p_mode_a)
        else $error("pin owner not per mode bit a");
    a_partner_off: assert property (p_partner_off)
        else $error("odd partner still active");
    a_wrap_tgl: assert property (p_wrap_tgl)
        else $error("no toggle on wrap");
    a_cmp_pin: assert property (p_cmp_pin)
        else $error("wrong pin level after match");
    a_cmp_flag: assert property (p_cmp_flag)
        else $error("no flag after match");
    a_cap_flag: assert property (p_cap_flag)
        else $error("no flag after active edge");

    c_cap: cover property (chan_irq[0] && !ctl_q[4]);
    c_cmp: cover property (cmp_md && counter_value == val_q);
    c_wrap: cover property (counter_wrap && channel_pin_oe[0]);
endmodule // tccp_chk

bind tccp_top tccp_chk u_tccp_chk
(
    .clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .counter_value, .counter_wrap, .counter_halt,
    .channel_pin_in, .channel_pin_out, .channel_pin_oe, .chan_irq
);

/* File: sim/tccp_pin_model.sv */
/* far side of the six channel pins: an outside source per pin.
   assumes the block's enable marks the pins it drives. */
module tccp_pin_model
(
    input  wire logic [5:0] pin_out,
    input  wire logic [5:0] pin_oe,
    input  wire logic [5:0] ext_level,
    output logic      [5:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // the block wins where it drives; the outside source holds the rest
    assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // tccp_pin_model

/* File: sim/tccp_top_tb_top.sv */
/* self-checking bench for tccp_top: reads are noted in a queue and a
   monitor compares them; assumes design files are compiled first. */
module tccp_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic [15:0] counter_value = 16'h1234;
    logic        counter_wrap = 1'b0;
    logic        counter_halt = 1'b0;
    logic [5:0]  ext_level = 6'h00;
    logic [5:0]  pin_in, pin_out, pin_oe, chan_irq;
    logic [7:0]  exp_q[$];
    logic        rd_seen = 1'b0;
    logic [7:0]  cfg[6];
    logic [15:0] cv;
    logic        hit;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          cycles = 0;

    always #20 clk_sys = ~clk_sys;

    tccp_top u_tccp_top (.clk_sys, .sys_rst, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .counter_value, .counter_wrap,
        .counter_halt, .channel_pin_in(pin_in), .channel_pin_out(pin_out),
        .channel_pin_oe(pin_oe), .chan_irq);
    tccp_pin_model u_tccp_pin_model (.pin_out, .pin_oe, .ext_level,
        .pin_level(pin_in));

    task automatic give_verdict();
        $display("mismatches %0d of %0d checks", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(logic [15:0] seen, logic [15:0] want);
        n_tests++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    task automatic step(int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // each access leaves one idle cycle so no strobe is set twice at once
    task automatic wr(logic [7:0] a, logic [7:0] d);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        step(1);
        reg_wr    <= 1'b0;
        step(1);
    endtask

    task automatic rd(logic [7:0] a, logic [7:0] want);
        exp_q.push_back(want);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        step(1);
        reg_rd   <= 1'b0;
        step(1);
    endtask

    task automatic pulse(logic [15:0] v, logic w);
        counter_value <= v;
        counter_wrap  <= w;
        step(1);
        counter_value <= 16'h0000;
        counter_wrap  <= 1'b0;
        step(2);
    endtask

    always @(posedge clk_sys)
    begin
        if (rd_seen)
            check(reg_rdata, exp_q.pop_front());
        rd_seen <= reg_rd;
    end

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end

    initial
    begin
        cv = 16'($urandom(49));
        step(3);
        sys_rst <= 1'b0;
        for (int c = 0; c < 6; c++)
            rd(8'(c * 4), 8'h00);
        rd(8'h20, 8'h00);
        for (int r = 0; r < 4; r++)
        begin
            for (int c = 0; c < 6; c++)
            begin
                cfg[c] = 8'($urandom) & (c % 2 ? 8'h5f : 8'h7f);
                if (c % 2 && cfg[c - 1][5])
                    cfg[c] = 8'h00;
                wr(8'(c * 4), cfg[c]);
            end
            for (int c = 0; c < 6; c++)
                rd(8'(c * 4), cfg[c]);
            // back to preset so no stale pin level looks like an edge
            for (int c = 0; c < 6; c++)
                wr(8'(c * 4), 8'h00);
        end
        for (int e = 1; e < 4; e++)
        begin
            wr(8'h00, 8'h40 | 8'(e << 2));
            rd(8'h00, 8'h40 | 8'(e << 2));
            wr(8'h00, 8'h40 | 8'(e << 2));
            for (int k = 0; k < 2; k++)
            begin
                cv = 16'($urandom);
                hit = k ? e[1] : e[0];
                counter_value <= cv;
                ext_level[0] <= ~ext_level[0];
                step(2);
                check(chan_irq[0], hit);
                if (hit)
                begin
                    rd(8'h01, cv[15:8]);
                    rd(8'h02, cv[7:0]);
                    rd(8'h00, 8'hc0 | 8'(e << 2));
                    wr(8'h00, 8'h40 | 8'(e << 2));
                end
            end
        end
        wr(8'h00, 8'h4c);
        counter_halt <= 1'b1;
        ext_level[0] <= ~ext_level[0];
        step(2);
        check(chan_irq[0], 1'b0);
        counter_halt <= 1'b0;
        ext_level[0] <= ~ext_level[0];
        step(2);
        check(chan_irq[0], 1'b1);
        rd(8'h00, 8'hcc);
        ext_level[0] <= ~ext_level[0];
        step(1);
        wr(8'h00, 8'h4c);
        rd(8'h00, 8'hcc);
        wr(8'h00, 8'h8c);
        check(chan_irq[0], 1'b0);
        rd(8'h00, 8'h8c);
        wr(8'h00, 8'h4c);
        rd(8'h00, 8'h4c);
        wr(8'h00, 8'hcc);
        rd(8'h00, 8'h4c);
        counter_halt  <= 1'b1;
        counter_value <= 16'h0000;
        wr(8'h01, 8'h01);
        wr(8'h02, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            cfg[0] = 8'h50 | 8'((i < 2 ? 3 - i : 1) << 2);
            wr(8'h00, cfg[0]);
            counter_halt <= 1'b0;
            pulse(16'h0100, 1'b0);
            check(pin_out[0], !i[0]);
            check(chan_irq[0], 1'b1);
            rd(8'h00, cfg[0] | 8'h80);
            wr(8'h00, cfg[0]);
        end
        wr(8'h00, 8'h5a);
        pulse(16'h0100, 1'b1);
        check(pin_out[0], 1'b1);
        pulse(16'h0000, 1'b1);
        check(pin_out[0], 1'b0);
        wr(8'h00, 8'h5b);
        check(pin_out[0], 1'b0);
        pulse(16'h0000, 1'b1);
        check(pin_out[0], 1'b1);
        pulse(16'h0100, 1'b0);
        check(pin_out[0], 1'b1);
        wr(8'h00, 8'h5a);
        check(pin_out[0], 1'b1);
        rd(8'h00, 8'hda);
        wr(8'h00, 8'h5c);
        wr(8'h01, 8'h02);
        pulse(16'h0200, 1'b0);
        check(chan_irq[0], 1'b0);
        wr(8'h02, 8'h00);
        pulse(16'h0200, 1'b0);
        check(chan_irq[0], 1'b1);
        step(2);
        give_verdict();
    end
endmodule // tccp_top_tb_top
